/* verilog/csr_pkg.sv */
// Constants and carrier types for the charger status and interrupt register bank.
// Assumes an 8-bit register port driven by the host-interface logic on mclk_in.
`default_nettype none
package csr_pkg;
	localparam logic [7:0] CSR_ADDR_RESV = 8'h70;
	localparam logic [7:0] CSR_ADDR_CTRL = 8'h71;
	localparam logic [7:0] CSR_ADDR_STAT = 8'h78;
	localparam logic [7:0] CSR_ADDR_SEL = 8'h79;
	localparam logic [7:0] CSR_ADDR_PHASE = 8'h7a;
	// Control byte: hold[7], reserved[6] (kept zero), total[5:4], pre[3:2], ovp[1:0]
	localparam logic [7:0] CSR_CTRL_MASK = 8'hbf;
	localparam logic [7:0] CSR_CTRL_RST = 8'h00;
	localparam logic [7:0] CSR_SEL_RST = 8'h00;
	localparam logic [3:0] CSR_MASTER_RST = 4'h0;
	localparam int CSR_HOLD_BIT = 7;
	localparam int CSR_TOT_LSB = 4;
	localparam int CSR_PRE_LSB = 2;
	localparam int CSR_OVP_LSB = 0;
	// Select byte bit positions
	localparam int CSR_SEL_TOT = 7;
	localparam int CSR_SEL_TIN = 6;
	localparam int CSR_SEL_SCON = 5;
	localparam int CSR_SEL_DIN = 4;
	localparam int CSR_SEL_PRE = 3;
	localparam int CSR_SEL_TOUT = 2;
	localparam int CSR_SEL_SDIS = 1;
	localparam int CSR_SEL_DOUT = 0;
	localparam int CSR_PHASE_LSB = 4;
	localparam int CSR_ADAPT_BIT = 1;

	// Live inputs from the analogue side and the charge state machine
	typedef struct packed {
		logic total_expired;
		logic pre_expired;
		logic thermal_ok;
		logic supply_valid;
		logic charge_done;
		logic adapter_high;
		logic [1:0] phase;
	} csr_live_s;

	// Control settings handed to the charger
	typedef struct packed {
		logic charge_hold;
		logic [1:0] total_timeout_select;
		logic [1:0] precondition_timeout_select;
		logic [1:0] overvoltage_threshold_select;
	} csr_ctrl_s;
endpackage : csr_pkg
`default_nettype wire

/* verilog/csr_charger_regs.sv */
// Charger control, interrupt enable, interrupt status and live condition registers.
// Assumes the host-interface logic gives single-cycle read and write strobes on
// mclk_in with an 8-bit address; read data follows one cycle after the read strobe.
// The interrupt pin is open drain: the testbench resolves the wire from the enable.
//
// Summary of operation
// - Hold bit set stops charging, clear resumes
// - Two-bit total time-out select, read/write
// - Two-bit precondition time-out select, read/write
// - Two-bit over-voltage threshold select, read/write
// - Total expiry interrupts when master and enable set
// - Precharge expiry interrupts when master and enable set
// - Thermal entry interrupts when master and enable set
// - Thermal exit interrupts when master and enable set
// - Supply connect interrupts when master and enable set
// - Supply disconnect interrupts when master and enable set
// - Done entry interrupts when master and enable set
// - Done exit interrupts when master and enable set
// - Master bits write enable, read pending status
// - Timer flag shows any time-out occurred
// - Thermal flag shows temperature in range
// - Supply flag shows valid input present
// - Done flag shows end-of-charge state
// - Two-bit field shows present charge phase
// - Adapter flag shows sense above threshold
// - Status only meaningful with supply in window
// - Interrupt request output is open drain
`default_nettype none
module csr_charger_regs (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire csr_pkg::csr_live_s live_in,
	input wire logic supply_in_window_in,
	output csr_pkg::csr_ctrl_s ctrl_out,
	output logic interrupt_request_n_out,
	output logic interrupt_request_n_oe_out
);
	import csr_pkg::*;

	logic [7:0] ctrl_q;
	logic [7:0] sel_q;
	logic [3:0] master_q;
	logic [3:0] pend_q;
	logic [3:0] pend_set;
	logic [3:0] pend_clr_ok;
	logic stat_rd;
	csr_live_s s1_q;
	csr_live_s s2_q;
	csr_live_s prev_q;
	logic win1_q;
	logic win2_q;
	logic prime_q;
	logic [7:0] rdata_d;
	logic irq_d;

	// Analogue and other-domain inputs pass two flops before use
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			s1_q <= '0;
			s2_q <= '0;
			win1_q <= 1'b0;
			win2_q <= 1'b0;
		end else begin
			s1_q <= live_in;
			s2_q <= s1_q;
			win1_q <= supply_in_window_in;
			win2_q <= win1_q;
		end
	end

	// Previous sample for edge detection; first sample after reset only primes
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			prev_q <= '0;
			prime_q <= 1'b0;
		end else begin
			prev_q <= s2_q;
			prime_q <= 1'b1;
		end
	end

	// Control register; bit 6 is reserved and forced to zero
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			ctrl_q <= CSR_CTRL_RST;
		end else if (reg_wr_in && reg_addr_in == CSR_ADDR_CTRL) begin
			ctrl_q <= reg_wdata_in & CSR_CTRL_MASK;
		end
	end

	// Interrupt select enables
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			sel_q <= CSR_SEL_RST;
		end else if (reg_wr_in && reg_addr_in == CSR_ADDR_SEL) begin
			sel_q <= reg_wdata_in;
		end
	end

	// Master enables live in the upper nibble of the status byte
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			master_q <= CSR_MASTER_RST;
		end else if (reg_wr_in && reg_addr_in == CSR_ADDR_STAT) begin
			master_q <= reg_wdata_in[7:4];
		end
	end

	// Qualified event edges; events are ignored outside the supply window,
	// except supply connect/disconnect which define that window themselves
	always_comb begin
		pend_set = 4'h0;
		if (prime_q) begin
			pend_set[3] = master_q[3] && (
				(sel_q[CSR_SEL_TOT] && s2_q.total_expired && !prev_q.total_expired) ||
				(sel_q[CSR_SEL_PRE] && s2_q.pre_expired && !prev_q.pre_expired));
			pend_set[2] = master_q[2] && win2_q && (
				(sel_q[CSR_SEL_TIN] && s2_q.thermal_ok && !prev_q.thermal_ok) ||
				(sel_q[CSR_SEL_TOUT] && !s2_q.thermal_ok && prev_q.thermal_ok));
			pend_set[1] = master_q[1] && (
				(sel_q[CSR_SEL_SCON] && s2_q.supply_valid && !prev_q.supply_valid) ||
				(sel_q[CSR_SEL_SDIS] && !s2_q.supply_valid && prev_q.supply_valid));
			pend_set[0] = master_q[0] && win2_q && (
				(sel_q[CSR_SEL_DIN] && s2_q.charge_done && !prev_q.charge_done) ||
				(sel_q[CSR_SEL_DOUT] && !s2_q.charge_done && prev_q.charge_done));
		end
		pend_set[3] = pend_set[3] && win2_q;
	end

	assign stat_rd = reg_rd_in && reg_addr_in == CSR_ADDR_STAT;
	assign pend_clr_ok = stat_rd ? 4'h0 : 4'hf;

	// Sticky pending bits; a new event in the read cycle survives the clear
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pend_q <= 4'h0;
		end else begin
			pend_q <= (pend_q & pend_clr_ok) | pend_set;
		end
	end

	// Read mux; reserved and unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_addr_in == CSR_ADDR_RESV) begin
			rdata_d = 8'h00;
		end else if (reg_addr_in == CSR_ADDR_CTRL) begin
			rdata_d = ctrl_q;
		end else if (reg_addr_in == CSR_ADDR_STAT) begin
			rdata_d = {pend_q,
				s2_q.total_expired | s2_q.pre_expired,
				s2_q.thermal_ok,
				s2_q.supply_valid,
				s2_q.charge_done};
		end else if (reg_addr_in == CSR_ADDR_SEL) begin
			rdata_d = sel_q;
		end else if (reg_addr_in == CSR_ADDR_PHASE) begin
			rdata_d[CSR_PHASE_LSB +: 2] = s2_q.phase;
			rdata_d[CSR_ADAPT_BIT] = s2_q.adapter_high;
		end
	end

	// Registered read data, held between reads
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_d;
		end
	end

	// Control fields to the charger, registered so they leave from flops
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			ctrl_out <= '0;
		end else begin
			ctrl_out.charge_hold <= ctrl_q[CSR_HOLD_BIT];
			ctrl_out.total_timeout_select <= ctrl_q[CSR_TOT_LSB +: 2];
			ctrl_out.precondition_timeout_select <= ctrl_q[CSR_PRE_LSB +: 2];
			ctrl_out.overvoltage_threshold_select <= ctrl_q[CSR_OVP_LSB +: 2];
		end
	end

	// Open-drain request: only ever drives low, released otherwise
	assign irq_d = |((pend_q & pend_clr_ok) | pend_set);
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			interrupt_request_n_out <= 1'b0;
			interrupt_request_n_oe_out <= 1'b0;
		end else begin
			interrupt_request_n_out <= 1'b0;
			interrupt_request_n_oe_out <= irq_d;
		end
	end
endmodule // csr_charger_regs
`default_nettype wire

/* tb/csr_charger_regs_monitor.sv */
// Checker on the charger register bank ports.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
module csr_charger_regs_monitor (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire csr_pkg::csr_live_s live_in,
	input wire logic supply_in_window_in,
	input wire csr_pkg::csr_ctrl_s ctrl_out,
	input wire logic interrupt_request_n_out,
	input wire logic interrupt_request_n_oe_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import csr_pkg::*;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	logic [3:0] quiet_q;
	csr_live_s live_q;
	// Cycles since live levels moved; old edges have drained once it passes 6
	always_ff @(posedge mclk_in) begin
		live_q <= live_in;
		if (sys_rst_in || live_q != live_in)
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hf)
			quiet_q <= quiet_q + 4'h1;
	end
	sequence stat_rd_s;
		reg_rd_in && reg_addr_in == CSR_ADDR_STAT;
	endsequence
	sequence ctrl_wr_s;
		reg_wr_in && reg_addr_in == CSR_ADDR_CTRL;
	endsequence
	ctrl_load_a: assert property (ctrl_wr_s |=> ##1
		{ctrl_out[6], 1'b0, ctrl_out[5:0]} == ($past(reg_wdata_in, 2) & CSR_CTRL_MASK))
		else $error("control byte not applied");
	resv_zero_a: assert property (reg_rd_in && reg_addr_in == CSR_ADDR_RESV |=>
		reg_rdata_out == 8'h00) else $error("reserved byte not zero");
	stat_flags_a: assert property (stat_rd_s ##0 quiet_q > 4'h6 |=> reg_rdata_out[3:0] ==
		{live_q.total_expired | live_q.pre_expired, live_q[5:3]}) else $error("flags wrong");
	phase_read_a: assert property (reg_rd_in && reg_addr_in == CSR_ADDR_PHASE &&
		quiet_q > 4'h6 |=> reg_rdata_out == {2'b00, live_q.phase, 2'b00, live_q.adapter_high,
		1'b0}) else $error("phase byte wrong");
	pin_low_a: assert property (!interrupt_request_n_out) else $error("pin data not low");
	oe_cause_a: assert property ($rose(interrupt_request_n_oe_out) |-> quiet_q < 4'h6)
		else $error("request without an event");
	oe_hold_a: assert property (interrupt_request_n_oe_out &&
		!(reg_rd_in && reg_addr_in == CSR_ADDR_STAT) |=>
		interrupt_request_n_oe_out) else $error("request dropped early");
	oe_drop_a: assert property (stat_rd_s ##0 quiet_q > 4'h6 |=>
		!interrupt_request_n_oe_out) else $error("request kept after read");
endmodule // csr_charger_regs_monitor
`default_nettype wire

/* tb/csr_live_model.sv */
// Charger side stand-in: live levels as the bench commands them.
// Assumes commands change at mclk_in rising edges.
`default_nettype none
module csr_live_model (
	input wire logic [7:0] cmd_in,
	output csr_pkg::csr_live_s live_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Levels only, no timing of the analogue parts
	assign live_out = csr_pkg::csr_live_s'(cmd_in);
endmodule // csr_live_model
`default_nettype wire

/* tb/csr_charger_regs_bench.sv */
// Bench for the charger register bank: accesses, controls and events.
// Assumes csr_pkg, the charger side model and the port checker.
`default_nettype none
module csr_charger_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import csr_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, win = 1'b1, oe, pin;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lv = 8'h00;
	logic [7:0] adr [5] = '{8'h70, 8'h71, 8'h78, 8'h79, 8'h7a};
	logic [7:0] evm [12] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h20, 8'h20, 8'h10, 8'h10, 8'h08,
		8'h08, 8'h03, 8'h04};
	logic [3:0] evp [12] = '{8, 0, 8, 0, 4, 4, 2, 2, 1, 1, 0, 0};
	int mismatches = 0, checked = 0, cyc = 0;
	csr_live_s live;
	csr_ctrl_s ctrl;
	wire irq_n = oe ? pin : 1'b1; // Pull-up on the open-drain wire
	csr_live_model model (.cmd_in(lv), .live_out(live));
	csr_charger_regs dut (.mclk_in(clk), .sys_rst_in(rst), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .live_in(live),
		.supply_in_window_in(win), .ctrl_out(ctrl), .interrupt_request_n_out(pin),
		.interrupt_request_n_oe_out(oe));
	initial forever #2.5 clk = ~clk;
	// Hang guard, well above the few hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 if (!w) check(rdata, d);
	endtask
	// Move live levels, then see the request and the status it leaves
	task automatic ev(input logic [7:0] m, input logic [3:0] p);
		@(posedge clk);
		lv <= lv ^ m;
		repeat (8) @(posedge clk);
		#1 check({7'h0, irq_n}, {7'h0, p == 4'h0});
		acc(0, CSR_ADDR_STAT, {p, lv[7] | lv[6], lv[5:3]});
		acc(0, CSR_ADDR_PHASE, {2'b00, lv[1:0], 2'b00, lv[2], 1'b0});
		check({7'h0, irq_n}, 8'h01);
	endtask
	task automatic tally_and_finish();
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		foreach (adr[i]) acc(0, adr[i], 8'h00);
		acc(1, CSR_ADDR_CTRL, 8'h96);
		acc(0, CSR_ADDR_CTRL, 8'h96);
		check({1'b0, ctrl}, 8'h56);
		acc(1, CSR_ADDR_CTRL, 8'h69);
		acc(0, CSR_ADDR_CTRL, 8'h29);
		check({1'b0, ctrl}, 8'h29);
		acc(1, CSR_ADDR_RESV, 8'hff);
		acc(1, CSR_ADDR_PHASE, 8'hff);
		acc(0, CSR_ADDR_RESV, 8'h00);
		acc(0, CSR_ADDR_PHASE, 8'h00);
		acc(1, CSR_ADDR_SEL, 8'hff);
		acc(0, CSR_ADDR_SEL, 8'hff);
		acc(1, CSR_ADDR_STAT, 8'hff);
		acc(0, CSR_ADDR_STAT, 8'h00);
		foreach (evm[i]) ev(evm[i], evp[i]);
		acc(1, CSR_ADDR_SEL, 8'h00);
		ev(8'h20, 4'h0);
		ev(8'h20, 4'h0);
		acc(1, CSR_ADDR_SEL, 8'hff);
		acc(1, CSR_ADDR_STAT, 8'h00);
		ev(8'h10, 4'h0);
		acc(1, CSR_ADDR_STAT, 8'hf0);
		@(posedge clk);
		win <= 1'b0;
		ev(8'h08, 4'h0);
		ev(8'h10, 4'h2);
		tally_and_finish();
	end
endmodule // csr_charger_regs_bench
bind csr_charger_regs csr_charger_regs_monitor mon (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .live_in(live_in),
	.supply_in_window_in(supply_in_window_in), .ctrl_out(ctrl_out),
	.interrupt_request_n_out(interrupt_request_n_out),
	.interrupt_request_n_oe_out(interrupt_request_n_oe_out));
`default_nettype wire
